// File: dv/dab_autobuf_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dab_autobuf_sva (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Control port
   input wire dab_pkg::dab_req_t     req,
   input wire logic [7:0]            rdata,
   input wire logic                  rvalid,
   // Stream and levels
   input wire logic                  rx_ready,
   input wire dab_pkg::dab_rx_stat_t rx_stat,
   input wire dab_pkg::dab_bit_t     tx_bit,
   input wire logic                  tx_valid,
   input wire logic                  tx_ready,
   input wire logic                  stuff_enable,
   input wire logic [3:0]            stuff_limit
);
   import dab_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Upper preamble bytes as software must see them, zero for audio
   wire logic [7:0] pc_hi = rx_stat.nonaudio ? rx_stat.pc_a[15:8] : 8'h00;
   wire logic [7:0] pd_hi = !rx_stat.nonaudio ? 8'h00 : rx_stat.subframe_mode ? rx_stat.pc_b[15:8] : rx_stat.pd[15:8];
   // Limit level that a write must produce, zero while stuffing is off
   wire logic [3:0] lim_in = !req.wdata[6] ? 4'h0 : (req.wdata[3:0] > DAB_LIMIT_MAX) ? DAB_LIMIT_MAX : req.wdata[3:0];
   property p_rvalid; req.rd |=> rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("no rvalid");
   property p_ratio; req.rd && req.addr == DAB_ADDR_RATIO_HI |=> rdata == {1'b0, $past(rx_stat.ratio[14:8])}; endproperty
   a_ratio: assert property (p_ratio) else $error("ratio byte");
   property p_pc; req.rd && req.addr == DAB_ADDR_PC_HI |=> rdata == $past(pc_hi); endproperty
   a_pc: assert property (p_pc) else $error("pc byte");
   property p_pd; req.rd && req.addr == DAB_ADDR_PD_HI |=> rdata == $past(pd_hi); endproperty
   a_pd: assert property (p_pd) else $error("pd byte");
   property p_res; req.rd && req.addr == DAB_ADDR_AUTOBUF |=> !rdata[7]; endproperty
   a_res: assert property (p_res) else $error("reserved bit");
   // Level lags the register by one cycle
   property p_stuff; req.wr && req.addr == DAB_ADDR_AUTOBUF |=> ##1 stuff_enable == $past(req.wdata[6], 2); endproperty
   a_stuff: assert property (p_stuff) else $error("stuff enable");
   property p_limit; stuff_limit <= DAB_LIMIT_MAX; endproperty
   a_limit: assert property (p_limit) else $error("limit above eight");
   // Limit level follows the written code two cycles on
   property p_lim_val; req.wr && req.addr == DAB_ADDR_AUTOBUF |=> ##1 stuff_limit == $past(lim_in, 2); endproperty
   a_lim_val: assert property (p_lim_val) else $error("stuff limit value");
   // A stalled word must not be lost or altered
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit); endproperty
   a_hold: assert property (p_hold) else $error("tx word dropped");
   c_read: cover property (rvalid);
   c_stall: cover property (tx_valid && !tx_ready);
   c_full: cover property (!rx_ready);
   c_stuff: cover property (stuff_enable && stuff_limit == DAB_LIMIT_MAX);
endmodule
bind dab_autobuf dab_autobuf_sva u_sva (.clk, .rst_n, .req, .rdata, .rvalid, .rx_ready, .rx_stat, .tx_bit,
   .tx_valid, .tx_ready, .stuff_enable, .stuff_limit);
`default_nettype wire

// File: dv/digital_audio_autobuffer_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module digital_audio_autobuffer_status_tb;
   import dab_pkg::*;
   logic         clk, rst_n, rx_valid, tx_ready, stall, rvalid, rx_ready, tx_valid, stuff_enable;
   logic [7:0]   rdata, ctl, rq[$];
   logic [3:0]   stuff_limit, lim_e, tq[$];
   logic [15:0]  pd;
   logic [31:0]  lf = 32'h6DDF;
   dab_req_t     req;
   dab_bit_t     rx_bit, tx_bit;
   dab_rx_stat_t rx_stat, st;
   int           fail_count = 0, tests_run = 0;
   // Control words: both enables, each alone, none, stuffing short, off, and clamped
   logic [7:0]   cv[7] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h72, 8'h3A, 8'h6F};
   dab_autobuf DUT (.clk, .rst_n, .req, .rdata, .rvalid, .rx_bit, .rx_valid, .rx_ready, .rx_stat,
      .tx_bit, .tx_valid, .tx_ready, .stuff_enable, .stuff_limit);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Random transmitter stalls so the buffer is exercised
   always @(negedge clk) begin
      lf       <= nx(lf);
      tx_ready <= !stall && lf[0];
   end
   // One compare task per kind of result
   task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD rdata exp %h got %h", e, g);
      end
   endtask
   task automatic chk_tx(input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD tx_bit exp %h got %h", e, g);
      end
   endtask
   task automatic chk_lvl(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Oldest note is the expected result; empty queue means an extra result
   always @(posedge clk) begin
      if (rst_n && rvalid) chk_rd(rq.size() ? rq.pop_front() : 8'hXX, rdata);
      if (rst_n && tx_valid && tx_ready) chk_tx(tq.size() ? tq.pop_front() : 4'hX, tx_bit);
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk) req <= '{1'b1, 1'b0, a, d};
      @(negedge clk) req <= '0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk) req <= '0;
   endtask
   // Offer one bit and note what the transmitter must see
   task automatic snd(input logic [3:0] b);
      if (b[3] ? ctl[5] : ctl[4]) tq.push_back(b);
      if (b[3] && b[0] && ctl[5] && ctl[6]) repeat (lim_e) tq.push_back(4'h8);
      @(negedge clk) rx_bit <= b;
      rx_valid <= 1'b1;
      do @(posedge clk); while (!rx_ready);
      @(negedge clk) rx_valid <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Whole run is a few hundred cycles
   initial begin
      #500000;
      fail_count++;
      stop_test;
   end
   initial begin
      {rst_n, rx_valid, stall} = '0;
      {req, rx_bit, ctl, rx_stat} = '0;
      lim_e = 4'h0;
      repeat (20) @(negedge clk);
      rst_n <= 1'b1;
      rd(DAB_ADDR_AUTOBUF, DAB_AUTOBUF_RESET);
      wr(DAB_ADDR_AUTOBUF, 8'hFF);
      wr(DAB_ADDR_RATIO_HI, 8'h00);
      rd(DAB_ADDR_AUTOBUF, DAB_AUTOBUF_MASK);
      rd(7'h18, 8'h00);
      // Audio, nonaudio, then per-subframe nonaudio
      for (int m = 0; m < 3; m++) begin
         st = {m != 0, m == 2, lf[14:0], lf[31:16], ~lf[15:0], lf[23:8]};
         pd = st.subframe_mode ? st.pc_b : st.pd;
         rx_stat <= st;
         rd(DAB_ADDR_RATIO_HI, {1'b0, st.ratio[14:8]});
         rd(DAB_ADDR_RATIO_LO, st.ratio[7:0]);
         rd(DAB_ADDR_PC_HI, st.nonaudio ? st.pc_a[15:8] : 8'h00);
         rd(DAB_ADDR_PC_LO, st.nonaudio ? st.pc_a[7:0] : 8'h00);
         rd(DAB_ADDR_PD_HI, st.nonaudio ? pd[15:8] : 8'h00);
         rd(DAB_ADDR_PD_LO, st.nonaudio ? pd[7:0] : 8'h00);
      end
      foreach (cv[i]) begin
         wr(DAB_ADDR_AUTOBUF, cv[i]);
         ctl = cv[i];
         lim_e = (ctl[3:0] > DAB_LIMIT_MAX) ? DAB_LIMIT_MAX : ctl[3:0];
         // Levels settle one cycle after the register
         @(negedge clk);
         chk_lvl("stuff_enable", {7'h00, ctl[6]}, {7'h00, stuff_enable});
         chk_lvl("stuff_limit", {4'h0, (ctl[6] ? lim_e : 4'h0)}, {4'h0, stuff_limit});
         snd(4'b1110);
         snd(4'b0011);
         snd(4'b1011);
         while (tq.size() != 0) @(posedge clk);
      end
      // Stall the transmitter until the buffer refuses
      stall <= 1'b1;
      repeat (3) snd(4'b1110);
      chk_lvl("rx_ready", 8'h00, {7'h00, rx_ready});
      stall <= 1'b0;
      snd(4'b1010);
      while (tq.size() != 0) @(posedge clk);
      // A stray extra word now meets an empty queue before the verdict
      repeat (20) @(posedge clk);
      stop_test;
   end
endmodule
`default_nettype wire

// File: src/dab_autobuf.sv
// Operation
// - User bits copied to transmitter when enabled
// - Channel status copied when its enable set
// - Zero stuffing between units only when enabled
// - Four-bit stuffing limit, zero to eight
// - Fifteen-bit rate ratio readable at 0x12/0x13
// - Burst Pc readable at 0x14/0x15 when nonaudio
// - Burst Pd readable at 0x16/0x17 when nonaudio
// - Preamble registers read zero unless nonaudio
// - Subframe mode puts channel B Pc in Pd
`timescale 1ns/1ps
`default_nettype none
module dab_autobuf (
   // Clock and reset
   input  wire  logic                  clk,
   input  wire  logic                  rst_n,
   // Control port
   input  wire  dab_pkg::dab_req_t     req,
   output var   logic [7:0]            rdata,
   output var   logic                  rvalid,
   // Receiver side stream and status
   input  wire  dab_pkg::dab_bit_t     rx_bit,
   input  wire  logic                  rx_valid,
   output var   logic                  rx_ready,
   input  wire  dab_pkg::dab_rx_stat_t rx_stat,
   // Transmitter side stream
   output var   dab_pkg::dab_bit_t     tx_bit,
   output var   logic                  tx_valid,
   input  wire  logic                  tx_ready,
   // Control levels to the transmitter
   output var   logic                  stuff_enable,
   output var   logic [3:0]            stuff_limit
);
   import dab_pkg::*;

   // Stuffing state: copy bits, or insert zeros after a unit end
   typedef enum logic [1:0] {
      DAB_COPY  = 2'b01,
      DAB_STUFF = 2'b10
   } dab_state_t;

   // Control register and derived fields
   logic [7:0]  ctrl_q;                 // Autobuffer control register
   logic [7:0]  ctrl_d;                 // Its next value
   logic        user_en;                // User bit copy enable
   logic        cs_en;                  // Channel status copy enable
   logic        stf_en;                 // Unit stuffing enable
   logic [3:0]  lim_raw;                // Limit as written
   logic [3:0]  lim;                    // Limit clamped to eight

   // Read path
   logic [7:0]  rd_mux;                 // Selected read byte
   logic [15:0] pc_vis;                 // Pc as seen by software
   logic [15:0] pd_vis;                 // Pd as seen by software

   // Two-entry buffer; two words can wait while the transmitter
   // stalls on a third held in tx_bit, so a stall drops nothing
   dab_bit_t    buf_q [2];              // Storage
   logic        wp_q;                   // Write pointer
   logic        rp_q;                   // Read pointer
   logic [1:0]  cnt_q;                  // Occupancy
   logic [1:0]  cnt_d;                  // Next occupancy
   logic        push;                   // Entry accepted
   logic        pop;                    // Entry leaves
   logic        keep;                   // Incoming bit passes filter

   // Stuffing sequencer
   dab_state_t  st_q;                   // Current state
   dab_state_t  st_d;                   // Next state
   logic [3:0]  zc_q;                   // Zeros left to insert
   logic [3:0]  zc_d;                   // Next count
   dab_bit_t    head;                   // Entry at the read side
   dab_bit_t    out_d;                  // Next transmitter bit
   logic        out_v_d;                // Next transmitter valid
   logic        slot_free;              // Output register may load

   // Field decode; copy enables act on the next bit offered, and bits
   // already in the buffer still leave under the old setting
   assign user_en = ctrl_q[DAB_BIT_USER_EN];
   assign cs_en   = ctrl_q[DAB_BIT_CS_EN];
   assign stf_en  = ctrl_q[DAB_BIT_STUFF_EN];
   assign lim_raw = ctrl_q[DAB_LIMIT_MSB:0];
   // Codes above eight are clamped, never trusted as larger counts
   assign lim     = (lim_raw > DAB_LIMIT_MAX) ? DAB_LIMIT_MAX : lim_raw;

   // Reserved bit 7 is masked off on write; writes to any other
   // offset, the read-only ones included, change nothing here
   assign ctrl_d = (req.wr && req.addr == DAB_ADDR_AUTOBUF) ?
                   (req.wdata & DAB_AUTOBUF_MASK) : ctrl_q;

   // Status comes from the decoder on this same clock, so it is
   // used directly with no synchroniser
   // Preambles hidden unless the stream is nonaudio
   assign pc_vis = rx_stat.nonaudio ? rx_stat.pc_a : 16'h0000;
   // Subframe mode swaps channel B Pc into the Pd pair
   assign pd_vis = !rx_stat.nonaudio ? 16'h0000 :
                   (rx_stat.subframe_mode ? rx_stat.pc_b : rx_stat.pd);

   // Read decode; unmapped addresses return zero. Bytes are read
   // live, so a value read in two halves may tear if it changes
   assign rd_mux =
      (req.addr == DAB_ADDR_AUTOBUF)  ? ctrl_q :
      (req.addr == DAB_ADDR_RATIO_HI) ? ({1'b0, rx_stat.ratio[14:8]} & DAB_RATIO_HI_MASK) :
      (req.addr == DAB_ADDR_RATIO_LO) ? rx_stat.ratio[7:0] :
      (req.addr == DAB_ADDR_PC_HI)    ? pc_vis[15:8] :
      (req.addr == DAB_ADDR_PC_LO)    ? pc_vis[7:0] :
      (req.addr == DAB_ADDR_PD_HI)    ? pd_vis[15:8] :
      (req.addr == DAB_ADDR_PD_LO)    ? pd_vis[7:0] : 8'h00;

   // Only enabled bit classes enter the buffer; others are dropped
   assign keep = rx_bit.is_user ? user_en : cs_en;
   // Dropped bits are still taken, so a disabled class never fills the buffer
   assign push = rx_valid && rx_ready && keep;
   assign head = buf_q[rp_q];
   assign slot_free = !tx_valid || tx_ready;
   // Occupancy after this edge; ready is registered from it
   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   // Output sequencer: copy, or after a user unit end insert zeros
   always_comb begin
      // By default the word stands until the transmitter takes it
      st_d    = st_q;
      zc_d    = zc_q;
      out_d   = tx_bit;
      out_v_d = tx_valid && !tx_ready;
      pop     = 1'b0;
      case (st_q)
         DAB_COPY: begin
            if (slot_free && cnt_q != 2'd0) begin
               pop     = 1'b1;
               out_d   = head;
               out_v_d = 1'b1;
               // Stuffing only with its enable and a nonzero limit
               if (stf_en && head.is_user && head.unit_end && lim != 4'h0) begin
                  st_d = DAB_STUFF;
                  zc_d = lim;
               end
            end
         end
         DAB_STUFF: begin
            if (slot_free) begin
               // A stuffed zero is a user bit on channel A
               out_d   = '{is_user: 1'b1, chan_b: 1'b0, bit_val: 1'b0, unit_end: 1'b0};
               out_v_d = 1'b1;
               zc_d    = zc_q - 4'h1;
               // Disabling mid-run ends stuffing after one more zero
               if (zc_q == 4'h1 || !stf_en) begin
                  st_d = DAB_COPY;
               end
            end
         end
         default: begin
            st_d = DAB_COPY;
         end
      endcase
   end

   // Control register and read answer; rdata keeps the last answer
   // so a slow reader may fetch it later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= DAB_AUTOBUF_RESET;
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         rdata  <= req.rd ? rd_mux : rdata;
         rvalid <= req.rd;
      end
   end

   // Buffer pointers, occupancy and the registered ready
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q    <= 2'd0;
         rx_ready <= 1'b1;
      end else begin
         wp_q     <= wp_q ^ push;
         rp_q     <= rp_q ^ pop;
         cnt_q    <= cnt_d;
         // Refuse the next bit once both entries are held
         rx_ready <= (cnt_d != 2'd2);
      end
   end

   // Buffer storage needs no reset: the count alone says which
   // entries hold a word
   always_ff @(posedge clk) begin
      if (push) begin
         buf_q[wp_q] <= rx_bit;
      end
   end

   // Sequencer and transmitter output register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q     <= DAB_COPY;
         zc_q     <= 4'h0;
         tx_bit   <= '0;
         tx_valid <= 1'b0;
      end else begin
         st_q     <= st_d;
         zc_q     <= zc_d;
         tx_bit   <= out_d;
         tx_valid <= out_v_d;
      end
   end

   // Control levels for the transmitter; the limit is forced to zero
   // while stuffing is off so no stale count is seen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stuff_enable <= 1'b0;
         stuff_limit  <= 4'h0;
      end else begin
         stuff_enable <= stf_en;
         stuff_limit  <= stf_en ? lim : 4'h0;
      end
   end
endmodule
`default_nettype wire

// File: src/dab_pkg.sv
package dab_pkg;
   // Register offsets on the control port (7-bit address)
   localparam logic [6:0] DAB_ADDR_AUTOBUF   = 7'h11;
   localparam logic [6:0] DAB_ADDR_RATIO_HI  = 7'h12;
   localparam logic [6:0] DAB_ADDR_RATIO_LO  = 7'h13;
   localparam logic [6:0] DAB_ADDR_PC_HI     = 7'h14;
   localparam logic [6:0] DAB_ADDR_PC_LO     = 7'h15;
   localparam logic [6:0] DAB_ADDR_PD_HI     = 7'h16;
   localparam logic [6:0] DAB_ADDR_PD_LO     = 7'h17;
   // Autobuffer control field positions
   localparam int DAB_BIT_STUFF_EN   = 6;
   localparam int DAB_BIT_USER_EN    = 5;
   localparam int DAB_BIT_CS_EN      = 4;
   localparam int DAB_LIMIT_MSB      = 3;
   // Writable bits of the control register; bit 7 is reserved
   localparam logic [7:0] DAB_AUTOBUF_MASK  = 8'h7F;
   localparam logic [7:0] DAB_AUTOBUF_RESET = 8'h00;
   // Largest legal stuffing limit
   localparam logic [3:0] DAB_LIMIT_MAX     = 4'h8;
   // Upper ratio byte holds seven bits
   localparam logic [7:0] DAB_RATIO_HI_MASK = 8'h7F;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dab_req_t;

   // One stream bit carried from receiver to transmitter
   typedef struct packed {
      logic is_user;  // User bit, else channel status bit
      logic chan_b;   // Channel B subframe
      logic bit_val;  // Bit value
      logic unit_end; // Last bit of an information unit
   } dab_bit_t;

   // Receiver status sampled from the decoder
   typedef struct packed {
      logic        nonaudio;
      logic        subframe_mode;
      logic [14:0] ratio;
      logic [15:0] pc_a;
      logic [15:0] pd;
      logic [15:0] pc_b;
   } dab_rx_stat_t;
endpackage
